// *** common/bitdec_regs.svh ***
/*
 Byte addresses, bit positions, fixed bit-address bases and code-target
 widths for the bit-address decoder and branch-target unit.
 Assumes inclusion by bare name from design files.
*/
`ifndef BITDEC_REGS_SVH
`define BITDEC_REGS_SVH

// Direct data space split
`define DIRECT_RAM_TOP 8'h7F
`define REG_AREA_BASE 8'h80
// Bit-addressable RAM bytes and their bit-address span
`define BIT_RAM_BYTE_BASE 8'h20
`define BIT_RAM_LAST_BIT 8'h7F
// Hardware register byte addresses (bit addressable)
`define TIMER_CONTROL_ADDR 8'h88
`define SERIAL_CONTROL_ADDR 8'h98
`define IRQ_ENABLE_ADDR 8'hA8
`define PORT_THREE_ADDR 8'hB0
`define IRQ_PRIORITY_ADDR 8'hB8
`define PROGRAM_STATUS_ADDR 8'hD0
// Reset values of the hosted registers
`define TIMER_CONTROL_RST 8'h00
`define SERIAL_CONTROL_RST 8'h00
`define IRQ_ENABLE_RST 8'h00
`define PORT_THREE_RST 8'hFF
`define IRQ_PRIORITY_RST 8'h00
`define PROGRAM_STATUS_RST 8'h00
// Defined bits of enable and priority bytes
`define IRQ_ENABLE_DEF_MASK 8'h9F
`define IRQ_PRIORITY_DEF_MASK 8'h1F
// Program status bit positions
`define STATUS_CARRY 3'd7
`define STATUS_AUX 3'd6
`define STATUS_USER0 3'd5
`define STATUS_BANK_HI 3'd4
`define STATUS_BANK_LO 3'd3
`define STATUS_OVF 3'd2
`define STATUS_PARITY 3'd0
// Timer control bit positions
`define TIMER_CTRL_RUN_ONE 3'd6
// Code targets
`define PAGE_BITS 11
`define PC_WIDTH 16

`endif

// *** common/bitdec_pkg.sv ***
/*
 Types for the bit-address decoder and branch-target unit.
 Assumes bitdec_regs.svh provides numeric constants.
*/
`default_nettype none
package bitdec_pkg;

   // Branch kinds presented by the sequencer
   typedef enum logic [2:0] {
      BR_NONE = 3'h0,
      BR_SHORT_REL = 3'h1,
      BR_COND_REL = 3'h2,
      BR_PAGE_JUMP = 3'h3,
      BR_PAGE_CALL = 3'h4,
      BR_LONG_JUMP = 3'h5,
      BR_LONG_CALL = 3'h6
   } branch_kind_t;

   // One branch request
   typedef struct packed {
      logic valid;
      branch_kind_t kind;
      logic taken;
      logic [15:0] pc_next;
      logic [7:0] opcode;
      logic [7:0] operand_a;
      logic [7:0] operand_b;
   } branch_req_t;

   // Bit-access request
   typedef struct packed {
      logic valid;
      logic [7:0] bit_addr;
      logic write;
      logic wdata;
   } bit_req_t;

   // Bit location answer
   typedef struct packed {
      logic valid;
      logic mapped;
      logic in_regs;
      logic [7:0] byte_addr;
      logic [2:0] bit_index;
      logic rdata;
   } bit_loc_t;

   // Branch answer
   typedef struct packed {
      logic valid;
      logic load_pc;
      logic [15:0] pc;
      logic push_ret;
      logic [15:0] ret_addr;
   } branch_ans_t;

   // Direct byte routing
   typedef struct packed {
      logic valid;
      logic to_regs;
      logic [6:0] ram_index;
   } byte_route_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01
   } unit_state_t;

   // Whole state of the unit
   typedef struct packed {
      unit_state_t st;
      logic [7:0] timer_control;
      logic [7:0] serial_control;
      logic [7:0] irq_enable;
      logic [7:0] port_three;
      logic [7:0] irq_priority;
      logic [7:0] program_status;
      logic [127:0] bit_ram;
      bit_loc_t loc;
      branch_ans_t br;
      byte_route_t route;
   } unit_state_all_t;

endpackage : bitdec_pkg
`default_nettype wire

// *** rtl/branch_bit_decode.sv ***
/*
 Bit-address decoder with the hosted bit-addressable bytes, direct-address
 router and branch-target computation of the core.
 Assumes the sequencer presents one-cycle requests on the core clock and
 that program memory fetches at the returned program counter.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bitdec_regs.svh"

module branch_bit_decode #(
   parameter int PC_BITS = `PC_WIDTH
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire bitdec_pkg::bit_req_t bit_req_i,
   input wire bitdec_pkg::branch_req_t branch_req_i,
   input wire logic direct_valid_i,
   input wire logic [7:0] direct_addr_i,
   input wire logic [7:0] port3_pins_i,
   output bitdec_pkg::bit_loc_t bit_loc_o,
   output bitdec_pkg::branch_ans_t branch_ans_o,
   output bitdec_pkg::byte_route_t byte_route_o,
   output logic [7:0] timer_control_reg_o,
   output logic [7:0] serial_control_reg_o,
   output logic [7:0] irq_enable_reg_o,
   output logic [7:0] port3_reg_o,
   output logic [7:0] irq_priority_reg_o,
   output logic [7:0] program_status_word_o
);
   import bitdec_pkg::*;

   // Counter width is fixed by the 64K code space
   if (PC_BITS != 16) begin : g_pc_bits_check
      $error("branch_bit_decode serves a 16-bit program counter only");
   end

   unit_state_all_t s_reg;
   unit_state_all_t s_next;

   // Port pins pass three flops; a change counts once stages two and three agree
   logic [7:0] pin_s1_reg;
   logic [7:0] pin_s2_reg;
   logic [7:0] pin_s3_reg;
   logic [7:0] pin_stable_reg;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_s1_reg <= 8'hFF;
         pin_s2_reg <= 8'hFF;
         pin_s3_reg <= 8'hFF;
         pin_stable_reg <= 8'hFF;
      end else begin
         pin_s1_reg <= port3_pins_i;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         // Take stage two where two and three agree, else hold the old level
         pin_stable_reg <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) |
                           (pin_stable_reg & (pin_s2_reg ^ pin_s3_reg));
      end
   end

   // Defined-bit masks, indexable by bit position
   localparam logic [7:0] EN_DEF_MASK = `IRQ_ENABLE_DEF_MASK;
   localparam logic [7:0] PRI_DEF_MASK = `IRQ_PRIORITY_DEF_MASK;

   // Decoded bit location
   logic [7:0] byte_addr;
   logic [2:0] bit_index;
   logic mapped;
   logic in_regs;
   logic [7:0] cur_byte;
   logic [7:0] upd_byte;

   // Bit address split: low half are RAM bytes 20H..2FH, high half are
   // register bytes whose address is the bit address with index cleared
   always_comb begin
      bit_index = bit_req_i.bit_addr[2:0];
      if (!bit_req_i.bit_addr[7]) begin
         in_regs = 1'b0;
         byte_addr = `BIT_RAM_BYTE_BASE + {4'h0, bit_req_i.bit_addr[6:3]};
      end else begin
         in_regs = 1'b1;
         byte_addr = {bit_req_i.bit_addr[7:3], 3'b000};
      end
      // Only the listed register bytes decode; other register bytes are unmapped, RAM bytes always map
      case (byte_addr)
         `TIMER_CONTROL_ADDR, `SERIAL_CONTROL_ADDR, `PORT_THREE_ADDR,
         `PROGRAM_STATUS_ADDR: mapped = 1'b1;
         `IRQ_ENABLE_ADDR: mapped = EN_DEF_MASK[bit_index];
         `IRQ_PRIORITY_ADDR: mapped = PRI_DEF_MASK[bit_index];
         default: mapped = !in_regs;
      endcase
   end

   // Select the addressed byte for read-modify-write
   always_comb begin
      case (byte_addr)
         `TIMER_CONTROL_ADDR: cur_byte = s_reg.timer_control;
         `SERIAL_CONTROL_ADDR: cur_byte = s_reg.serial_control;
         `IRQ_ENABLE_ADDR: cur_byte = s_reg.irq_enable & `IRQ_ENABLE_DEF_MASK;
         `PORT_THREE_ADDR: cur_byte = s_reg.port_three & pin_stable_reg;
         `IRQ_PRIORITY_ADDR: cur_byte = s_reg.irq_priority & `IRQ_PRIORITY_DEF_MASK;
         `PROGRAM_STATUS_ADDR: cur_byte = s_reg.program_status;
         default: cur_byte = s_reg.bit_ram[{bit_req_i.bit_addr[6:3], 3'b000} +: 8];
      endcase
      upd_byte = cur_byte;
      upd_byte[bit_index] = bit_req_i.wdata;
   end

   // Branch arithmetic on the already advanced counter
   logic [15:0] rel_target;
   logic [15:0] page_target;
   logic [15:0] long_target;

   always_comb begin
      rel_target = branch_req_i.pc_next +
                   {{8{branch_req_i.operand_a[7]}}, branch_req_i.operand_a};
      page_target = {branch_req_i.pc_next[15:`PAGE_BITS],
                     branch_req_i.opcode[7:5], branch_req_i.operand_a};
      long_target = {branch_req_i.operand_a, branch_req_i.operand_b};
   end

   // Next-state logic: one registered answer per request
   always_comb begin
      s_next = s_reg;
      s_next.st = (bit_req_i.valid || branch_req_i.valid) ? ST_BUSY : ST_IDLE;
      s_next.loc = '0;
      s_next.br = '0;
      s_next.route = '0;
      if (bit_req_i.valid) begin
         s_next.loc.valid = 1'b1;
         s_next.loc.mapped = mapped;
         s_next.loc.in_regs = in_regs;
         s_next.loc.byte_addr = byte_addr;
         s_next.loc.bit_index = bit_index;
         s_next.loc.rdata = mapped ? cur_byte[bit_index] : 1'b0;
         // Writes to unmapped bits are dropped
         if (bit_req_i.write && mapped) begin
            case (byte_addr)
               `TIMER_CONTROL_ADDR: s_next.timer_control = upd_byte;
               `SERIAL_CONTROL_ADDR: s_next.serial_control = upd_byte;
               `IRQ_ENABLE_ADDR: s_next.irq_enable = upd_byte;
               `PORT_THREE_ADDR: s_next.port_three = upd_byte;
               `IRQ_PRIORITY_ADDR: s_next.irq_priority = upd_byte;
               `PROGRAM_STATUS_ADDR: s_next.program_status = upd_byte;
               default: s_next.bit_ram[{bit_req_i.bit_addr[6:3], 3'b000} +: 8] = upd_byte;
            endcase
         end
      end
      if (branch_req_i.valid) begin
         s_next.br.valid = 1'b1;
         s_next.br.pc = branch_req_i.pc_next;
         case (branch_req_i.kind)
            BR_SHORT_REL: begin
               s_next.br.load_pc = 1'b1;
               s_next.br.pc = rel_target;
            end
            BR_COND_REL: begin
               s_next.br.load_pc = branch_req_i.taken;
               s_next.br.pc = branch_req_i.taken ? rel_target : branch_req_i.pc_next;
            end
            BR_PAGE_JUMP, BR_PAGE_CALL: begin
               s_next.br.load_pc = 1'b1;
               s_next.br.pc = page_target;
               s_next.br.push_ret = (branch_req_i.kind == BR_PAGE_CALL);
               s_next.br.ret_addr = branch_req_i.pc_next;
            end
            BR_LONG_JUMP, BR_LONG_CALL: begin
               s_next.br.load_pc = 1'b1;
               s_next.br.pc = long_target;
               s_next.br.push_ret = (branch_req_i.kind == BR_LONG_CALL);
               s_next.br.ret_addr = branch_req_i.pc_next;
            end
            default: begin
               s_next.br.load_pc = 1'b0;
            end
         endcase
      end
      // Direct byte route by the top address bit
      if (direct_valid_i) begin
         s_next.route.valid = 1'b1;
         s_next.route.to_regs = (direct_addr_i > `DIRECT_RAM_TOP);
         s_next.route.ram_index = direct_addr_i[6:0];
      end
   end

   // Single state register
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= '0;
         s_reg.timer_control <= `TIMER_CONTROL_RST;
         s_reg.serial_control <= `SERIAL_CONTROL_RST;
         s_reg.irq_enable <= `IRQ_ENABLE_RST;
         s_reg.port_three <= `PORT_THREE_RST;
         s_reg.irq_priority <= `IRQ_PRIORITY_RST;
         s_reg.program_status <= `PROGRAM_STATUS_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // All outputs straight from the state register
   assign bit_loc_o = s_reg.loc;
   assign branch_ans_o = s_reg.br;
   assign byte_route_o = s_reg.route;
   assign timer_control_reg_o = s_reg.timer_control;
   assign serial_control_reg_o = s_reg.serial_control;
   assign irq_enable_reg_o = s_reg.irq_enable; // Undefined bits never stored
   assign port3_reg_o = s_reg.port_three;
   assign irq_priority_reg_o = s_reg.irq_priority; // Undefined bits never stored
   assign program_status_word_o = s_reg.program_status;

endmodule : branch_bit_decode
`default_nettype wire

// *** bench/branch_bit_decode_monitor.sv ***
/* Checker for the bit decoder and branch unit.
 Assumes it is bound onto branch_bit_decode. */
`timescale 1ns/100ps
`default_nettype none
module bbd_monitor (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire bitdec_pkg::bit_req_t bit_req_i,
   input wire bitdec_pkg::branch_req_t branch_req_i,
   input wire logic direct_valid_i,
   input wire logic [7:0] direct_addr_i,
   input wire bitdec_pkg::bit_loc_t bit_loc_o,
   input wire bitdec_pkg::branch_ans_t branch_ans_o,
   input wire bitdec_pkg::byte_route_t byte_route_o
);
   import bitdec_pkg::*;
   bit_req_t bq;
   branch_req_t rq;
   logic [7:0] dq;
   // Requests kept one cycle, since answers come one edge later
   always_ff @(posedge clk_sys_i) begin
      bq <= bit_req_i;
      rq <= branch_req_i;
      dq <= direct_addr_i;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   a_bit_index: assert property (bit_req_i.valid |=> bit_loc_o.valid && bit_loc_o.bit_index == bq.bit_addr[2:0])
      else $error("bit index wrong");
   a_reg_byte: assert property (bit_req_i.valid && bit_req_i.bit_addr[7]
      |=> bit_loc_o.in_regs && bit_loc_o.byte_addr == {bq.bit_addr[7:3], 3'h0}) else $error("register byte wrong");
   a_ram_byte: assert property (bit_req_i.valid && !bit_req_i.bit_addr[7]
      |=> bit_loc_o.mapped && !bit_loc_o.in_regs && bit_loc_o.byte_addr == {4'h2, bq.bit_addr[6:3]})
      else $error("ram byte wrong");
   a_enable_hole: assert property (bit_req_i.valid && bit_req_i.bit_addr inside {8'hAD, 8'hAE}
      |=> !bit_loc_o.mapped && !bit_loc_o.rdata) else $error("undefined bit answered");
   a_route_split: assert property (direct_valid_i |=> byte_route_o.valid && byte_route_o.to_regs == dq[7])
      else $error("route wrong");
   a_rel_target: assert property (branch_req_i.valid && branch_req_i.taken
      && branch_req_i.kind inside {BR_SHORT_REL, BR_COND_REL}
      |=> branch_ans_o.load_pc && branch_ans_o.pc == rq.pc_next + {{8{rq.operand_a[7]}}, rq.operand_a})
      else $error("relative target wrong");
   a_page_target: assert property (branch_req_i.valid && branch_req_i.kind inside {BR_PAGE_JUMP, BR_PAGE_CALL}
      |=> branch_ans_o.pc == {rq.pc_next[15:11], rq.opcode[7:5], rq.operand_a}) else $error("page target wrong");
   a_long_target: assert property (branch_req_i.valid && branch_req_i.kind inside {BR_LONG_JUMP, BR_LONG_CALL}
      |=> branch_ans_o.load_pc && branch_ans_o.pc == {rq.operand_a, rq.operand_b}) else $error("long target wrong");
   a_call_return: assert property (branch_req_i.valid && branch_req_i.kind inside {BR_PAGE_CALL, BR_LONG_CALL}
      |=> branch_ans_o.push_ret && branch_ans_o.ret_addr == rq.pc_next) else $error("return address wrong");
   c_call: cover property (branch_ans_o.push_ret);
   c_unmapped: cover property (bit_loc_o.valid && !bit_loc_o.mapped);
   c_regs: cover property (byte_route_o.valid && byte_route_o.to_regs);
endmodule : bbd_monitor

bind branch_bit_decode bbd_monitor i_bbd_monitor (.clk_sys_i, .rstn_i, .bit_req_i, .branch_req_i, .direct_valid_i,
   .direct_addr_i, .bit_loc_o, .branch_ans_o, .byte_route_o);
`default_nettype wire

// *** bench/code_fetch_model.sv ***
/* Program memory side: fetches where the branch answer points.
 Assumes the answer is a one-cycle pulse. */
`timescale 1ns/100ps
`default_nettype none
module code_fetch_model (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire bitdec_pkg::branch_ans_t ans_i,
   output logic [15:0] fetch_pc_o,
   output logic [15:0] ret_top_o
);
   import bitdec_pkg::*;
   // Fetch follows each load; one-deep stack is enough for these tests
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fetch_pc_o <= 16'h0000;
         ret_top_o <= 16'h0000;
      end else if (ans_i.valid) begin
         if (ans_i.load_pc) fetch_pc_o <= ans_i.pc;
         if (ans_i.push_ret) ret_top_o <= ans_i.ret_addr;
      end
   end
endmodule : code_fetch_model
`default_nettype wire

// *** bench/test_branch_bit_decode.sv ***
/* Bench for branch_bit_decode: bit access, routing, branch targets.
 Assumes the fetch model on the branch answer. */
`timescale 1ns/100ps
`default_nettype none
module test_branch_bit_decode;
   import bitdec_pkg::*;
   logic clk_sys_i, rstn_i, direct_valid_i;
   logic [7:0] direct_addr_i, port3_pins_i, tc, sc, irq_en, port_lat, irq_pri, stat_word;
   bit_req_t bit_req_i;
   branch_req_t branch_req_i;
   bit_loc_t bit_loc_o;
   branch_ans_t branch_ans_o;
   byte_route_t byte_route_o;
   logic [15:0] fetch_pc, ret_top;
   logic [7:0] bases [5] = '{8'h88, 8'h98, 8'hA8, 8'hB8, 8'hD0};
   logic [7:0] masks [5] = '{8'hFF, 8'hFF, 8'h9F, 8'h1F, 8'hFF};
   int failures = 0;
   int n_checks = 0;
   branch_bit_decode i_branch_bit_decode (.clk_sys_i, .rstn_i, .bit_req_i, .branch_req_i, .direct_valid_i,
      .direct_addr_i, .port3_pins_i, .bit_loc_o, .branch_ans_o, .byte_route_o, .timer_control_reg_o(tc),
      .serial_control_reg_o(sc), .irq_enable_reg_o(irq_en), .port3_reg_o(port_lat),
      .irq_priority_reg_o(irq_pri), .program_status_word_o(stat_word));
   code_fetch_model i_code_fetch_model (.clk_sys_i, .rstn_i, .ans_i(branch_ans_o), .fetch_pc_o(fetch_pc),
      .ret_top_o(ret_top));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] reg_at(input logic [7:0] b);
      case (b)
         8'h88: return tc;
         8'h98: return sc;
         8'hA8: return irq_en;
         8'hB8: return irq_pri;
         default: return stat_word;
      endcase
   endfunction : reg_at
   // Request held until the next call, so back-to-back never re-edges valid
   task automatic bit_op(input logic [7:0] a, input logic w, input logic d);
      bit_req_i = '{1'b1, a, w, d};
      @(negedge clk_sys_i);
      chk({8'h00, bit_loc_o.valid, 4'h0, bit_loc_o.bit_index}, {8'h00, 1'b1, 4'h0, a[2:0]});
   endtask : bit_op
   task automatic br(input branch_kind_t k, input logic t, input logic [15:0] pn, input logic [7:0] op, a, b,
         input logic [15:0] exp, input logic ld, input logic psh);
      branch_req_i = '{1'b1, k, t, pn, op, a, b};
      @(negedge clk_sys_i);
      chk({13'h0, branch_ans_o.valid, branch_ans_o.load_pc, branch_ans_o.push_ret}, {13'h0, 1'b1, ld, psh});
      chk(branch_ans_o.pc, exp);
      @(negedge clk_sys_i);
      if (ld) chk(fetch_pc, exp);
      if (psh) chk(ret_top, pn);
   endtask : br
   task automatic rest();
      bit_req_i = '0;
      branch_req_i = '0;
      direct_valid_i = 1'b0;
      @(negedge clk_sys_i);
   endtask : rest
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Watchdog against a hung sequence
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      failures++;
      wrap_up();
   end
   initial begin
      rstn_i = 1'b0;
      bit_req_i = '0;
      branch_req_i = '0;
      direct_valid_i = 1'b0;
      direct_addr_i = 8'h00;
      port3_pins_i = 8'hFF;
      repeat (5) @(negedge clk_sys_i);
      rstn_i = 1'b1;
      chk({tc, sc}, 16'h0000);
      chk({irq_en, port_lat}, 16'h00FF);
      chk({irq_pri, stat_word}, 16'h0000);
      bit_op(8'h8E, 1'b1, 1'b1);
      chk({bit_loc_o.byte_addr, tc}, 16'h8840);
      foreach (bases[r]) begin
         for (int i = 0; i < 8; i++) bit_op(bases[r] + 8'(i), 1'b1, 1'b1);
         chk({8'h00, reg_at(bases[r])}, {8'h00, masks[r]});
      end
      bit_op(8'hAF, 1'b1, 1'b0);
      bit_op(8'hAE, 1'b0, 1'b0);
      chk({7'h0, bit_loc_o.mapped, irq_en}, 16'h001F);
      bit_op(8'hBF, 1'b1, 1'b1);
      chk({7'h0, bit_loc_o.mapped, irq_pri}, 16'h001F);
      bit_op(8'hC3, 1'b0, 1'b0);
      chk({15'h0, bit_loc_o.mapped}, 16'h0000);
      bit_op(8'h7F, 1'b1, 1'b1);
      bit_op(8'h7F, 1'b0, 1'b0);
      chk({bit_loc_o.byte_addr, bit_loc_o.mapped, bit_loc_o.in_regs, bit_loc_o.rdata, 5'h07}, 16'h2FA7);
      bit_op(8'h00, 1'b0, 1'b0);
      chk({bit_loc_o.byte_addr, 7'h0, bit_loc_o.rdata}, 16'h2000);
      bit_op(8'hB3, 1'b1, 1'b0);
      chk({8'h00, port_lat}, 16'h00F7);
      rest();
      port3_pins_i = 8'hFB;
      repeat (6) @(negedge clk_sys_i);
      bit_op(8'hB2, 1'b0, 1'b0);
      chk({15'h0, bit_loc_o.rdata}, 16'h0000);
      bit_op(8'hB4, 1'b0, 1'b0);
      chk({15'h0, bit_loc_o.rdata}, 16'h0001);
      rest();
      foreach (masks[r]) begin
         direct_valid_i = 1'b1;
         direct_addr_i = masks[r] ^ 8'h80;
         @(negedge clk_sys_i);
         chk({7'h0, byte_route_o.valid, byte_route_o.to_regs, byte_route_o.ram_index},
            {7'h0, 1'b1, ~masks[r][7], direct_addr_i[6:0]});
      end
      rest();
      br(BR_SHORT_REL, 1'b1, 16'h1000, 8'h80, 8'h80, 8'h00, 16'h0F80, 1'b1, 1'b0);
      br(BR_COND_REL, 1'b1, 16'h1000, 8'h40, 8'h7F, 8'h00, 16'h107F, 1'b1, 1'b0);
      br(BR_COND_REL, 1'b0, 16'h1000, 8'h40, 8'h7F, 8'h00, 16'h1000, 1'b0, 1'b0);
      br(BR_PAGE_JUMP, 1'b1, 16'h0800, 8'hE1, 8'h23, 8'h00, 16'h0F23, 1'b1, 1'b0);
      br(BR_PAGE_CALL, 1'b1, 16'h1234, 8'h51, 8'hFF, 8'h00, 16'h12FF, 1'b1, 1'b1);
      br(BR_LONG_CALL, 1'b1, 16'h0010, 8'h12, 8'hFF, 8'hFE, 16'hFFFE, 1'b1, 1'b1);
      br(BR_LONG_JUMP, 1'b1, 16'h0020, 8'h02, 8'hFF, 8'hFF, 16'hFFFF, 1'b1, 1'b0);
      rest();
      wrap_up();
   end
endmodule : test_branch_bit_decode
`default_nettype wire
